// ---- pim_irq_mask.sv ----
// The APB slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - eight-bit enable register at 8Ch, all bits read/write, zero after reset
// - bit 7 enables the parallel port access interrupt, else masked
// - bit 6 enables the conversion-done interrupt, else blocked
// - bit 5 enables the serial receive full interrupt, else suppressed
// - without a parallel port, bit 7 is reserved; the hardware holds it at zero
// - nothing reaches core_req unless the peripheral enable is also set; a new flag can still raise irq through status bit 1
// - flags set on their condition regardless of enables; enables gate only
module pim_irq_mask
  import pim_pkg::*;
#(
  parameter bit HAS_PARALLEL_PORT = 1'b1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] src_event,
  output logic core_req,
  output logic periph_pending,
  output logic irq
);

  // ----------------------------------------------------------------
  // state and bus decode
  // ----------------------------------------------------------------
  pim_state_t st_r;
  pim_state_t st_nxt;
  logic [7:0] flags;
  logic [7:0] flag_clr;
  logic [7:0] mask_bits;
  logic [7:0] gated;
  logic wr_cyc;
  logic rd_cyc;
  logic hit;
  logic any_gated;
  logic [1:0] ev;

  // access-phase strobes; the answer itself is built from the setup cycle
  assign wr_cyc = psel && penable && pwrite;
  assign rd_cyc = psel && penable && !pwrite;
  assign hit = paddr inside {PIM_MASK_OFS, PIM_CTRL_OFS, PIM_FLAG_OFS, PIM_FCLR_OFS,
                             PIM_STAT_OFS, PIM_SCLR_OFS, PIM_SEN_OFS};
  assign mask_bits = st_r.mask;
  assign flag_clr = (wr_cyc && paddr == PIM_FCLR_OFS && pstrb[0]) ? pwdata[7:0] : 8'h00;

  // ----------------------------------------------------------------
  // source flags, one instance per source
  // ----------------------------------------------------------------
  // each enable only selects which flag joins the request
  assign gated = flags & mask_bits;
  assign any_gated = |gated;

  genvar gi;
  generate
    for (gi = 0; gi < PIM_NSRC; gi++) begin : g_flag
      pim_flag_bit u_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set_pulse(src_event[gi]),
        .clr_pulse(flag_clr[gi]),
        .flag_r(flags[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // a registered answer costs no wait state: the master sees it in its access cycle
  always_comb begin
    st_nxt = st_r;
    st_nxt.flags = flags;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    // request needs both peripheral and global enable
    st_nxt.periph_pending = any_gated;
    st_nxt.core_req = any_gated && st_r.peripheral_global_en && st_r.global_irq_en;
    ev[PIM_EV_REQ_RISE] = st_nxt.core_req && !st_r.core_req;
    ev[PIM_EV_FLAG_NEW] = |(flags & ~st_r.flags); // rise against last cycle's copy
    // zero-wait apb: answer and pready registered from the setup cycle, both seen in the access cycle
    if (psel && !penable) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = !hit;
      st_nxt.prdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          PIM_MASK_OFS: st_nxt.prdata[7:0] = st_r.mask;
          PIM_CTRL_OFS: begin
            st_nxt.prdata[PIM_BIT_GLOBAL_EN] = st_r.global_irq_en;
            st_nxt.prdata[PIM_BIT_PERIPH_EN] = st_r.peripheral_global_en;
          end
          PIM_FLAG_OFS: st_nxt.prdata[7:0] = flags;
          PIM_STAT_OFS: st_nxt.prdata[1:0] = st_r.stat;
          PIM_SEN_OFS: st_nxt.prdata[1:0] = st_r.stat_en;
          default: st_nxt.prdata = 32'h0000_0000;
        endcase
      end
    end
    if (wr_cyc && pstrb[0]) begin
      unique case (paddr)
        PIM_MASK_OFS: begin
          st_nxt.mask = pwdata[7:0];
          // without the parallel port bit 7 is reserved and held at zero
          if (!HAS_PARALLEL_PORT) begin
            st_nxt.mask.parallel_port_access_en = 1'b0;
          end
        end
        PIM_CTRL_OFS: begin
          st_nxt.global_irq_en = pwdata[PIM_BIT_GLOBAL_EN];
          st_nxt.peripheral_global_en = pwdata[PIM_BIT_PERIPH_EN];
        end
        PIM_SEN_OFS: st_nxt.stat_en = pwdata[1:0];
        default: ;
      endcase
    end
    // status events: set wins over the clear
    if (wr_cyc && pstrb[0] && paddr == PIM_SCLR_OFS) begin
      st_nxt.stat = st_r.stat & ~pwdata[1:0];
    end
    st_nxt.stat = st_nxt.stat | ev;
    st_nxt.irq = |(st_nxt.stat & st_nxt.stat_en);
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // every output comes straight from the state register
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign core_req = st_r.core_req;
  assign periph_pending = st_r.periph_pending;
  assign irq = st_r.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // bus side: zero wait states, and pready stands for one cycle only
  a_bus_answer: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  a_read_answer: assert property (@(posedge pclk) disable iff (!presetn)
      rd_cyc |-> pready)
    else $error("read access without pready");
  a_write_answer: assert property (@(posedge pclk) disable iff (!presetn)
      wr_cyc |-> pready)
    else $error("write access without pready");
  a_bus_error: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> (pslverr == !$past(hit)))
    else $error("pslverr does not match the address decode");

  // register side: the enable byte only moves on a write with the low strobe
  a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_cyc && pstrb[0] && paddr == PIM_MASK_OFS && HAS_PARALLEL_PORT)
      |=> (st_r.mask == $past(pwdata[7:0])))
    else $error("enable register did not take write");
  a_mask_strobe: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_cyc && !pstrb[0] && paddr == PIM_MASK_OFS) |=> $stable(st_r.mask))
    else $error("enable register moved without strobe");
  a_mask_read: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == PIM_MASK_OFS) |=> (prdata == {24'h00_0000, $past(st_r.mask)}))
    else $error("enable register read back wrong");
  a_mask_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      !HAS_PARALLEL_PORT |-> !st_r.mask.parallel_port_access_en)
    else $error("reserved enable bit set");
  a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_cyc && pstrb[0] && paddr == PIM_CTRL_OFS) |=> (st_r.global_irq_en == $past(pwdata[PIM_BIT_GLOBAL_EN])
      && st_r.peripheral_global_en == $past(pwdata[PIM_BIT_PERIPH_EN])))
    else $error("control enables did not take write");

  // gating: a flag joins the request only through its enable and both control enables
  a_req_gated: assert property (@(posedge pclk) disable iff (!presetn)
      core_req |-> ($past(st_r.peripheral_global_en) && $past(st_r.global_irq_en)))
    else $error("request without peripheral enable");
  a_req_follows: assert property (@(posedge pclk) disable iff (!presetn)
      (|(flags & mask_bits) && st_r.peripheral_global_en && st_r.global_irq_en) |=> core_req)
    else $error("enabled flag gave no request");
  a_req_masked: assert property (@(posedge pclk) disable iff (!presetn)
      core_req |-> $past(|(flags & mask_bits)))
    else $error("request without an enabled flag");
  a_pending_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      ((flags & mask_bits) == 8'h00) |=> !periph_pending)
    else $error("pending without an enabled flag");
  a_masked_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      (flags[PIM_BIT_PARALLEL] && !mask_bits[PIM_BIT_PARALLEL] && (flags & mask_bits) == 8'h00)
      |=> !periph_pending)
    else $error("masked source leaked through");
  a_convert_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (flags == 8'h40 && mask_bits == 8'h40) |=> periph_pending)
    else $error("conversion enable did not pass flag");
  a_rx_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (flags == 8'h20 && mask_bits == 8'hDF) |=> !periph_pending)
    else $error("receive enable low did not block");
  a_low_gate: assert property (@(posedge pclk) disable iff (!presetn)
      ((flags[4:0] & mask_bits[4:0]) != 5'h00) |=> periph_pending)
    else $error("low source enable did not pass flag");

  // status: an event in the cycle of its clear still lands
  a_stat_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      (ev != 2'h0) |=> ((st_r.stat & $past(ev)) == $past(ev)))
    else $error("status event lost to its clear");

  c_req_raised: cover property (@(posedge pclk) disable iff (!presetn) $rose(core_req));
  c_irq_raised: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_set_clear: cover property (@(posedge pclk) disable iff (!presetn) |(src_event & flag_clr));
  c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  c_reserved_drop: cover property (@(posedge pclk) disable iff (!presetn)
      wr_cyc && pstrb[0] && paddr == PIM_MASK_OFS && pwdata[PIM_BIT_PARALLEL] && !HAS_PARALLEL_PORT);

endmodule
`default_nettype wire

// ---- pim_pkg.sv ----
package pim_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ----------------------------------------------------------------
  localparam logic [11:0] PIM_MASK_OFS = 12'h08C;
  localparam logic [11:0] PIM_CTRL_OFS = 12'h090;
  localparam logic [11:0] PIM_FLAG_OFS = 12'h094;
  localparam logic [11:0] PIM_FCLR_OFS = 12'h098;
  localparam logic [11:0] PIM_STAT_OFS = 12'h09C;
  localparam logic [11:0] PIM_SCLR_OFS = 12'h0A0;
  localparam logic [11:0] PIM_SEN_OFS = 12'h0A4;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int PIM_NSRC = 8;
  localparam int PIM_BIT_PARALLEL = 7;
  localparam int PIM_BIT_PERIPH_EN = 6;
  localparam int PIM_BIT_GLOBAL_EN = 7;
  localparam logic [7:0] PIM_MASK_RST = 8'h00;
  localparam logic [1:0] PIM_CTRL_RST = 2'h0;
  localparam logic [1:0] PIM_STAT_RST = 2'h0;
  localparam int PIM_EV_REQ_RISE = 0;
  localparam int PIM_EV_FLAG_NEW = 1;

  // enable bits, bit 7 down to bit 0
  typedef struct packed {
    logic parallel_port_access_en;
    logic converter_done_en;
    logic serial_rx_full_en;
    logic serial_tx_empty_en;
    logic sync_serial_done_en;
    logic capture_compare_one_en;
    logic timer_two_match_en;
    logic timer_one_overflow_en;
  } pim_en_t;

  // whole state of the top module
  typedef struct packed {
    pim_en_t mask;
    logic global_irq_en;
    logic peripheral_global_en;
    logic [7:0] flags;
    logic [1:0] stat;
    logic [1:0] stat_en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic core_req;
    logic periph_pending;
    logic irq;
  } pim_state_t;

endpackage

// ---- pim_flag_bit.sv ----
`timescale 1ns/10ps
`default_nettype none
// one sticky source flag: set wins over clear
module pim_flag_bit
  import pim_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set_pulse,
  input wire logic clr_pulse,
  output logic flag_r
);

  // flag is set by its source regardless of any enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else if (set_pulse) begin
      flag_r <= 1'b1;
    end else if (clr_pulse) begin
      flag_r <= 1'b0;
    end
  end

  a_flag_set_sticky: assert property (@(posedge pclk) disable iff (!presetn) set_pulse |=> flag_r)
    else $error("flag not set after source event");
  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn) (clr_pulse && !set_pulse) |=> !flag_r)
    else $error("flag not cleared by software");

endmodule
`default_nettype wire

// ---- peripheral_irq_enable_mask_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module peripheral_irq_enable_mask_tb
  import pim_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus signals and design instance
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] src_event = 8'h00;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready, pslverr, core_req, periph_pending, irq, e, nopar_pending;
  int miscompares = 0;
  int n_tests = 0;

  // 200 MHz core clock
  always #2.5 pclk = ~pclk;

  pim_irq_mask pim_irq_mask_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_event(src_event), .core_req(core_req), .periph_pending(periph_pending), .irq(irq));

  // second copy built without the parallel port; only its pending output is watched
  pim_irq_mask #(.HAS_PARALLEL_PORT(1'b0)) pim_irq_mask_nopar_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(), .pready(),
    .pslverr(), .src_event(src_event), .core_req(), .periph_pending(nopar_pending), .irq());

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  // request held until pready is seen high at a rising edge; only the watchdog ends the wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rq,
                     output logic re);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, q, e);
    chk("prdata", x, q);
  endtask

  // outputs are registered, so let a fixed number of edges pass
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic pulse(input logic [7:0] v);
    @(posedge pclk) src_event <= v;
    @(posedge pclk) src_event <= 8'h00;
  endtask

  task automatic print_verdict;
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(PIM_MASK_OFS, {24'h00_0000, PIM_MASK_RST});
    chk("pslverr", 32'h0, {31'h0, e});
    rd(PIM_CTRL_OFS, {24'h00_0000, PIM_CTRL_RST, 6'h00});
    rd(PIM_FLAG_OFS, 32'h0);
    wr(PIM_MASK_OFS, 32'hFFFFFFFF);
    rd(PIM_MASK_OFS, 32'h000000FF);
    // the copy without a parallel port keeps bit 7 at zero, so that source never pends there
    pulse(8'h80);
    tick(3);
    chk("periph_pending", 32'h1, {31'h0, periph_pending});
    chk("core_req", 32'h0, {31'h0, core_req});
    chk("nopar_pending", 32'h0, {31'h0, nopar_pending});
    // a write without the low byte strobe must leave the mask alone
    pstrb <= 4'hE;
    wr(PIM_MASK_OFS, 32'h0);
    pstrb <= 4'hF;
    rd(PIM_MASK_OFS, 32'h000000FF);
    wr(PIM_MASK_OFS, 32'h000000A5);
    rd(PIM_MASK_OFS, 32'h000000A5);
    apb(1'b0, 12'hFFC, 32'h0, q, e);
    chk("pslverr", 32'h1, {31'h0, e});
    chk("unmapped", 32'h0, q);
    // flags latch even with every enable off, but nothing is requested
    wr(PIM_MASK_OFS, 32'h0);
    pulse(8'hFF);
    rd(PIM_FLAG_OFS, 32'h000000FF);
    tick(3);
    chk("periph_pending", 32'h0, {31'h0, periph_pending});
    // each enable bit passes its own source only
    wr(PIM_CTRL_OFS, 32'h000000C0);
    for (int i = 0; i < 8; i++) begin
      wr(PIM_FCLR_OFS, 32'h000000FF);
      rd(PIM_FLAG_OFS, 32'h0);
      pulse(8'h01 << i);
      wr(PIM_MASK_OFS, ~(32'h1 << i));
      tick(3);
      chk("periph_pending", 32'h0, {31'h0, periph_pending});
      chk("core_req", 32'h0, {31'h0, core_req});
      wr(PIM_MASK_OFS, 32'h1 << i);
      tick(3);
      chk("periph_pending", 32'h1, {31'h0, periph_pending});
      chk("core_req", 32'h1, {31'h0, core_req});
    end
    // both control enables are needed to reach the core
    wr(PIM_CTRL_OFS, 32'h00000040);
    tick(3);
    chk("core_req", 32'h0, {31'h0, core_req});
    chk("periph_pending", 32'h1, {31'h0, periph_pending});
    wr(PIM_CTRL_OFS, 32'h00000080);
    tick(3);
    chk("core_req", 32'h0, {31'h0, core_req});
    // status, enable and clear of the interrupt line
    wr(PIM_SCLR_OFS, 32'h00000003);
    wr(PIM_SEN_OFS, 32'h00000001);
    rd(PIM_STAT_OFS, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(PIM_CTRL_OFS, 32'h000000C0);
    tick(3);
    rd(PIM_STAT_OFS, 32'h00000001);
    chk("irq", 32'h1, {31'h0, irq});
    wr(PIM_SEN_OFS, 32'h0);
    tick(2);
    chk("irq", 32'h0, {31'h0, irq});
    wr(PIM_SEN_OFS, 32'h00000001);
    tick(2);
    chk("irq", 32'h1, {31'h0, irq});
    wr(PIM_SCLR_OFS, 32'h00000001);
    tick(2);
    chk("irq", 32'h0, {31'h0, irq});
    rd(PIM_STAT_OFS, 32'h0);
    // a source held high through its own clear keeps the flag: set wins
    src_event <= 8'h01;
    wr(PIM_FCLR_OFS, 32'h00000001);
    src_event <= 8'h00;
    rd(PIM_FLAG_OFS, 32'h00000081);
    rd(PIM_STAT_OFS, 32'h00000002);
    wr(PIM_SEN_OFS, 32'h00000002);
    tick(2);
    chk("irq", 32'h1, {31'h0, irq});
    wr(PIM_FCLR_OFS, 32'h00000001);
    rd(PIM_FLAG_OFS, 32'h00000080);
    wr(PIM_SCLR_OFS, 32'h00000002);
    rd(PIM_STAT_OFS, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    // a second reset in mid-run returns every register to zero
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    rd(PIM_MASK_OFS, {24'h00_0000, PIM_MASK_RST});
    rd(PIM_FLAG_OFS, 32'h0);
    chk("core_req", 32'h0, {31'h0, core_req});
    chk("irq", 32'h0, {31'h0, irq});
    print_verdict;
  end

  // watchdog: the sequence needs only a few hundred cycles
  initial begin
    #100000;
    miscompares++;
    print_verdict;
  end
endmodule
`default_nettype wire
